// file: core/dcsf_defines.svh
// Offsets, field positions, reset values and widths of the DMA status-flag block
`ifndef DCSF_DEFINES_SVH
`define DCSF_DEFINES_SVH
`define DCSF_NCH          8
`define DCSF_ADDR_W       8
`define DCSF_OFF_COLL     8'h00
`define DCSF_OFF_ACT      8'h04
`define DCSF_OFF_IRQ_STAT 8'h08
`define DCSF_OFF_IRQ_MASK 8'h0c
`define DCSF_LAST_LSB     8
`define DCSF_LAST_MSB     11
`define DCSF_LAST_NONE    4'hf
`define DCSF_RESP_OKAY    2'h0
`define DCSF_RESP_SLVERR  2'h2
`endif

// file: core/dcsf_pkg.sv
// Types shared by the DMA status-flag block
`include "dcsf_defines.svh"
package dcsf_pkg;
  typedef struct packed {
    logic [`DCSF_ADDR_W-1:0] awaddr;
    logic                    awvalid;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    wvalid;
    logic                    bready;
    logic [`DCSF_ADDR_W-1:0] araddr;
    logic                    arvalid;
    logic                    rready;
  } dcsf_axi_req_type;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } dcsf_axi_rsp_type;
  typedef struct packed {
    logic [`DCSF_NCH-1:0] xfer_done;
    logic [`DCSF_NCH-1:0] ram_collision;
    logic [`DCSF_NCH-1:0] buf_sel;
  } dcsf_chan_type;
  typedef struct packed {
    logic                    aw_full;
    logic [`DCSF_ADDR_W-1:0] aw_addr;
    logic                    w_full;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    dcsf_axi_rsp_type        rsp;
    logic [`DCSF_NCH-1:0]    ram_write_collision_flag;
    logic [3:0]              last_active_channel;
    logic [`DCSF_NCH-1:0]    pingpong_buffer_status;
    logic [`DCSF_NCH-1:0]    irq_status;
    logic [`DCSF_NCH-1:0]    irq_mask;
    logic                    irq;
  } dcsf_state_type;
endpackage

// file: core/dcsf_status.sv
// DMA channel status flags with an AXI4-Lite register slave and one interrupt
//
// Behaviour
// (RULE_01) Each channel's RAM write collision flag sets on a detected collision, else stays clear.
// (RULE_02) Last active channel field resets to all ones; codes 1000 to 1110 never produced.
// (RULE_03) Each completed transfer loads the field with that channel's binary number; when several complete in one cycle, the code loads only the highest.
// (RULE_04) Channel 7 ping-pong bit reads 1 for buffer B selected, 0 for A; resets 0.
// (RULE_05) Channels 0 to 6 report their own buffer selection the same way.
// (RULE_06) Activity register is read-only; writes ignored; bits 15 to 12 read zero.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcsf_defines.svh"
module dcsf_status (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite slave
  input  wire dcsf_pkg::dcsf_axi_req_type axi_req,
  output var  dcsf_pkg::dcsf_axi_rsp_type axi_rsp,
  // Channel engine events and levels
  input  wire dcsf_pkg::dcsf_chan_type    chan,
  // Interrupt
  output logic                           irq
);
  import dcsf_pkg::*;

  dcsf_state_type st;
  dcsf_state_type next_st;
  logic [3:0]     done_code;
  logic           do_write;
  logic [`DCSF_ADDR_W-1:0] wa;
  logic [`DCSF_ADDR_W-1:0] ra;
  logic [15:0]    clr_bits;

  assign axi_rsp = st.rsp;
  assign irq     = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Channel number of a completed transfer; highest channel wins a tie
  always_comb begin
    done_code = 4'h0;
    for (int i = 0; i < `DCSF_NCH; i++) begin
      if (chan.xfer_done[i]) begin
        done_code = 4'(i); // see RULE_03
      end
    end
  end

  assign wa       = {st.aw_addr[`DCSF_ADDR_W-1:2], 2'h0};
  assign ra       = {axi_req.araddr[`DCSF_ADDR_W-1:2], 2'h0};
  assign do_write = st.aw_full && st.w_full && !st.rsp.bvalid;
  // Only the two low byte lanes hold register bits
  assign clr_bits = st.w_data[15:0] & {{8{st.w_strb[1]}}, {8{st.w_strb[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    // Address and data are taken in either order and held until both are in
    if (axi_req.awvalid && st.rsp.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.rsp.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = axi_req.wdata;
      next_st.w_strb = axi_req.wstrb;
    end
    if (st.rsp.bvalid && axi_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    // Event flags: clear first, so a set in the same cycle wins
    if (do_write) begin
      next_st.aw_full    = 1'b0;
      next_st.w_full     = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp  = `DCSF_RESP_OKAY;
      case (wa)
        `DCSF_OFF_COLL: begin
          next_st.ram_write_collision_flag = st.ram_write_collision_flag & ~clr_bits[`DCSF_NCH-1:0];
        end
        `DCSF_OFF_ACT: begin
          // Read-only: the write is answered and dropped
          next_st.rsp.bresp = `DCSF_RESP_OKAY; // see RULE_06
        end
        `DCSF_OFF_IRQ_STAT: begin
          next_st.irq_status = st.irq_status & ~clr_bits[`DCSF_NCH-1:0];
        end
        `DCSF_OFF_IRQ_MASK: begin
          next_st.irq_mask = clr_bits[`DCSF_NCH-1:0];
        end
        default: begin
          next_st.rsp.bresp = `DCSF_RESP_SLVERR;
        end
      endcase
    end
    next_st.ram_write_collision_flag = next_st.ram_write_collision_flag | chan.ram_collision; // see RULE_01
    next_st.irq_status = next_st.irq_status | chan.xfer_done;
    if (|chan.xfer_done) begin
      next_st.last_active_channel = done_code; // see RULE_02, see RULE_03
    end
    next_st.pingpong_buffer_status = chan.buf_sel; // see RULE_04, see RULE_05
    // Read channel: one outstanding read, answered the cycle after it is taken
    if (st.rsp.rvalid && axi_req.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st.rsp.arready) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rresp  = `DCSF_RESP_OKAY;
      next_st.rsp.rdata  = 32'h0;
      case (ra)
        `DCSF_OFF_COLL: begin
          next_st.rsp.rdata[`DCSF_NCH-1:0] = st.ram_write_collision_flag;
        end
        `DCSF_OFF_ACT: begin
          // Upper nibble is left at zero
          next_st.rsp.rdata[`DCSF_LAST_MSB:`DCSF_LAST_LSB] = st.last_active_channel; // see RULE_06
          next_st.rsp.rdata[`DCSF_NCH-1:0] = st.pingpong_buffer_status;
        end
        `DCSF_OFF_IRQ_STAT: begin
          next_st.rsp.rdata[`DCSF_NCH-1:0] = st.irq_status;
        end
        `DCSF_OFF_IRQ_MASK: begin
          next_st.rsp.rdata[`DCSF_NCH-1:0] = st.irq_mask;
        end
        default: begin
          next_st.rsp.rresp = `DCSF_RESP_SLVERR;
        end
      endcase
    end
    next_st.rsp.awready = !next_st.aw_full && !next_st.rsp.bvalid;
    next_st.rsp.wready  = !next_st.w_full && !next_st.rsp.bvalid;
    next_st.rsp.arready = !next_st.rsp.rvalid;
    // Taken from the next state so the pin rises on the same edge as the status bit
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st                     <= '0;
      st.last_active_channel <= `DCSF_LAST_NONE; // see RULE_02
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_coll_set;
    chan.ram_collision[3] |=> st.ram_write_collision_flag[3];
  endproperty
  a_coll_set: assert property (p_coll_set) else $error("collision flag not set"); // see RULE_01

  property p_coll_cause;
    $rose(st.ram_write_collision_flag[0]) |-> $past(chan.ram_collision[0]);
  endproperty
  a_coll_cause: assert property (p_coll_cause) else $error("collision flag set without cause"); // see RULE_01

  property p_last_reset;
    $past(!aresetn) |-> st.last_active_channel == 4'hf;
  endproperty
  a_last_reset: assert property (p_last_reset) else $error("last channel not all ones after reset"); // see RULE_02

  property p_last_legal;
    st.last_active_channel <= 4'h7 || st.last_active_channel == 4'hf;
  endproperty
  a_last_legal: assert property (p_last_legal) else $error("reserved last channel code"); // see RULE_02

  property p_last_load;
    chan.xfer_done == 8'h20 |=> st.last_active_channel == 4'h5;
  endproperty
  a_last_load: assert property (p_last_load) else $error("last channel not loaded"); // see RULE_03

  property p_pp7;
    chan.buf_sel[7] |=> st.pingpong_buffer_status[7];
  endproperty
  a_pp7: assert property (p_pp7) else $error("channel 7 ping-pong bit wrong"); // see RULE_04

  property p_pp_all;
    ##1 st.pingpong_buffer_status == $past(chan.buf_sel);
  endproperty
  a_pp_all: assert property (p_pp_all) else $error("ping-pong bits do not follow selection"); // see RULE_05

  property p_ro;
    (do_write && wa == `DCSF_OFF_ACT && chan.xfer_done == 8'h0) |=> $stable(st.last_active_channel);
  endproperty
  a_ro: assert property (p_ro) else $error("write changed read-only field"); // see RULE_06

  property p_rd_pad;
    $rose(axi_rsp.rvalid) |-> axi_rsp.rdata[31:12] == 20'h0;
  endproperty
  a_rd_pad: assert property (p_rd_pad) else $error("upper read bits not zero"); // see RULE_06

  property p_irq;
    (chan.xfer_done[2] && st.irq_mask[2] && !do_write) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_pp7_clear;
    !chan.buf_sel[7] |=> !st.pingpong_buffer_status[7];
  endproperty
  a_pp7_clear: assert property (p_pp7_clear) else $error("channel 7 ping-pong bit not clear"); // see RULE_04

  // A flag may only fall through a write of one to its bit
  property p_coll_clear;
    $fell(st.ram_write_collision_flag[2]) |-> $past(do_write && wa == `DCSF_OFF_COLL && clr_bits[2]);
  endproperty
  a_coll_clear: assert property (p_coll_clear) else $error("collision flag cleared without a write"); // see RULE_01

  property p_last_keep;
    chan.xfer_done == 8'h0 |=> $stable(st.last_active_channel);
  endproperty
  a_last_keep: assert property (p_last_keep) else $error("last channel changed without a transfer"); // see RULE_03

  // Answers must stand until the master takes them
  property p_bvalid_hold;
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");

  property p_rvalid_hold;
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped early");

  c_write: cover property (axi_rsp.bvalid && axi_req.bready);
  c_read_act: cover property ($rose(axi_rsp.rvalid) && axi_rsp.rdata[11:8] != 4'hf);
  c_coll: cover property ($rose(st.ram_write_collision_flag[1]));
  c_irq: cover property ($rose(irq));
  c_irq_ch2: cover property (chan.xfer_done[2] && st.irq_mask[2]);
endmodule // dcsf_status
`default_nettype wire

// file: test/dcsf_chan_model.sv
// Channel engine model driving done, collision and buffer-select lines
`timescale 1ns/1ps
`default_nettype none
module dcsf_chan_model (
  // Clock
  input  wire logic                    aclk,
  // Commands from the bench
  input  wire logic                    fire,
  input  wire logic                    cfire,
  input  wire logic [2:0]              fch,
  input  wire logic [7:0]              sel,
  // Channel lines
  output var  dcsf_pkg::dcsf_chan_type chan
);
  import dcsf_pkg::*;
  // One-cycle pulses, as a real engine gives once per transfer
  always_ff @(posedge aclk) begin
    chan.xfer_done     <= 8'(fire) << fch;
    chan.ram_collision <= 8'(cfire) << fch;
    chan.buf_sel       <= sel;
  end
endmodule // dcsf_chan_model
`default_nettype wire

// file: test/tb_dcsf_status.sv
// Testbench of the DMA status-flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_dcsf_status;
  import dcsf_pkg::*;
  logic             aclk = 0;
  logic             aresetn = 0;
  logic             fire = 0;
  logic             cfire = 0;
  logic             irq;
  logic [2:0]       fch = 0;
  logic [7:0]       sel = 0;
  logic [7:0]       coll = 0;
  logic [31:0]      rd;
  logic [1:0]       rr;
  int               error_cnt = 0;
  int               compares = 0;
  dcsf_axi_req_type req = '0;
  dcsf_axi_rsp_type rsp;
  dcsf_chan_type    chan;
  // Rows: channel, buffer selects, expected activity word; channels out of order
  logic [27:0] rows [8] = '{28'h3a503a5, 28'h0800080, 28'h7010701, 28'h5ff05ff,
                            28'h1000100, 28'h65a065a, 28'h20f020f, 28'h4f004f0};
  always #2.5 aclk = ~aclk;
  dcsf_status dcsf_status_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .chan(chan), .irq(irq));
  dcsf_chan_model dcsf_chan_model_i (.aclk(aclk), .fire(fire), .cfire(cfire), .fch(fch), .sel(sel), .chan(chan));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo;
    error_cnt++;
    $display("[FAIL] handshake exp answer got none");
    final_report();
  endtask
  task automatic rst;
    aresetn <= 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    {req.awaddr, req.awvalid, req.wdata, req.wstrb, req.wvalid, req.bready} <= {a, 1'b1, d, 4'hf, 2'b11};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 0;
      if (rsp.wready) req.wvalid <= 0;
      if (rsp.bvalid) break;
    end
    req.bready <= 0;
    rr = rsp.bresp;
    if (n == 50) tmo();
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    {req.araddr, req.arvalid, req.rready} <= {a, 2'b11};
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 0;
      if (rsp.rvalid) break;
    end
    req.rready <= 0;
    {rd, rr} = {rsp.rdata, rsp.rresp};
    if (n == 50) tmo();
  endtask
  task automatic ckr(input string nm, input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    `CHK(nm, e, rd)
  endtask
  // Fixed wait covers model, flag and buffer-select lags
  task automatic ev(input logic [2:0] c, input logic [7:0] s);
    @(posedge aclk);
    {fire, cfire, fch, sel} <= {2'b11, c, s};
    @(posedge aclk);
    {fire, cfire} <= 2'b00;
    repeat (3) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    rst();
    for (i = 0; i < 8; i++) begin
      ev(rows[i][26:24], rows[i][23:16]);
      coll = coll | (8'h1 << rows[i][26:24]);
      ckr("activity", 8'h04, {16'h0, rows[i][15:0]});
      ckr("collision", 8'h00, {24'h0, coll});
      `CHK("irq masked", 1'b0, irq)
      $display("row %0d done", i);
    end
    wr(8'h04, 32'hffffffff);
    `CHK("ro write resp", 2'h0, rr)
    ckr("activity kept", 8'h04, 32'h000004f0);
    wr(8'h00, 32'h0000000f);
    ckr("collision clear", 8'h00, 32'h000000f0);
    wr(8'h10, 32'h1);
    `CHK("unmapped wr", 2'h2, rr)
    rdr(8'h10);
    `CHK("unmapped rd", 2'h2, rr)
    `CHK("unmapped rd data", 32'h0, rd)
    $display("bus tests done");
    wr(8'h0c, 32'h80);
    `CHK("irq on", 1'b1, irq)
    wr(8'h08, 32'h80);
    `CHK("irq cleared", 1'b0, irq)
    wr(8'h08, 32'h000000ff);
    wr(8'h0c, 32'h00000004);
    `CHK("irq idle", 1'b0, irq)
    ev(3'h2, 8'hf0);
    `CHK("irq ch2", 1'b1, irq)
    ckr("irq status", 8'h08, 32'h00000004);
    ckr("irq mask", 8'h0c, 32'h00000004);
    ckr("activity ch2", 8'h04, 32'h000002f0);
    wr(8'h08, 32'h00000004);
    `CHK("irq ch2 cleared", 1'b0, irq)
    $display("irq tests done");
    sel <= 8'h00;
    rst();
    ckr("reset activity", 8'h04, 32'h00000f00);
    ckr("reset collision", 8'h00, 32'h0);
    $display("reset tests done");
    final_report();
  end
endmodule // tb_dcsf_status
`default_nettype wire
